// *** hdl/lijl_pkg.sv ***
// Package with parameter addresses, codes, reset values and carrier types.
package lijl_pkg;
  localparam logic [15:0] ADDR_HOMING_POL = 16'h061C;
  localparam logic [15:0] ADDR_NEG_LIM_POL = 16'h061E;
  localparam logic [15:0] ADDR_POS_LIM_POL = 16'h0620;
  localparam logic [15:0] ADDR_QSTOP_REACT = 16'h0630;
  localparam logic [15:0] ADDR_LINE2_FUNC = 16'h0724;
  localparam logic [15:0] ADDR_LINE3_FUNC = 16'h0726;
  localparam logic [15:0] ADDR_LINE4_FUNC = 16'h0728;
  localparam logic [15:0] ADDR_SLOW_SPEED = 16'h2908;
  localparam logic [15:0] ADDR_FAST_SPEED = 16'h290A;
  localparam logic [15:0] ADDR_STEP_HI = 16'h290E;
  localparam logic [15:0] ADDR_STEP_LO = 16'h290F;
  localparam logic [15:0] ADDR_STEP_WAIT = 16'h2910;

  localparam logic [15:0] RST_HOMING_POL = 16'h0001;
  localparam logic [15:0] RST_NEG_LIM_POL = 16'h0001;
  localparam logic [15:0] RST_POS_LIM_POL = 16'h0001;
  localparam logic [15:0] RST_QSTOP_REACT = 16'h0006;
  localparam logic [15:0] RST_LINE_FUNC = 16'h0001;
  localparam logic [15:0] RST_SLOW_SPEED = 16'h003C;
  localparam logic [15:0] RST_FAST_SPEED = 16'h00B4;
  localparam logic [31:0] RST_STEP_DIST = 32'h0000_0014;
  localparam logic [15:0] RST_STEP_WAIT = 16'h01F4;

  localparam logic [15:0] SPEED_MIN = 16'h0001;
  localparam logic [15:0] SPEED_MAX = 16'h0BB8;
  localparam logic [15:0] WAIT_MIN = 16'h0001;
  localparam logic [15:0] WAIT_MAX = 16'h7FFF;

  localparam logic [15:0] POL_OFF = 16'h0000;
  localparam logic [15:0] POL_NC = 16'h0001;
  localparam logic [15:0] POL_NO = 16'h0002;

  localparam logic [15:0] FN_IN_FREE = 16'h0001;
  localparam logic [15:0] FN_IN_FAULT_RESET = 16'h0002;
  localparam logic [15:0] FN_IN_ENABLE = 16'h0003;
  localparam logic [15:0] FN_IN_HALT = 16'h0004;
  localparam logic [15:0] FN_IN_JOG_POS = 16'h0009;
  localparam logic [15:0] FN_IN_JOG_NEG = 16'h000A;
  localparam logic [15:0] FN_IN_JOG_FAST = 16'h000B;
  localparam logic [15:0] FN_IN_HOME_SW = 16'h0014;
  localparam logic [15:0] FN_IN_NEG_LIMIT = 16'h0016;
  localparam logic [15:0] FN_OUT_FREE = 16'h0065;
  localparam logic [15:0] FN_OUT_NO_FAULT = 16'h0066;
  localparam logic [15:0] FN_OUT_READY = 16'h0067;

  localparam logic [15:0] QS_FAULT = 16'hFFFF;
  localparam logic [15:0] QS_HOLD = 16'h0006;
  localparam logic [3:0] STATE_FAULT = 4'h9;
  localparam logic [3:0] STATE_QSTOP = 4'h7;

  typedef struct packed {
    logic fast;
    logic neg;
    logic pos;
  } lijl_jog_s;

  typedef enum logic [2:0] {
    JOG_IDLE = 3'b001,
    JOG_POS = 3'b010,
    JOG_NEG = 3'b100
  } lijl_jog_e;
endpackage : lijl_pkg

// *** hdl/lijl_top.sv ***
// Local I/O function, limit switch, jog and quick-stop control logic.
// How it works
// RL1: Line 2 takes inputs incl. negative limit.
// RL2: Lines 3 and 4 lack limit function.
// RL3: Fault reset and enable only in local mode.
// RL4: Function writes blocked when enabled, used at power-on.
// RL5: Negative limit: 0 off, 1 NC, 2 NO.
// RL6: Positive limit same coding, locked while enabled.
// RL7: Homing switch honoured only during homing move.
// RL8: Switch polarities take effect at stage enable.
// RL9: Bits choose positive, negative, and fast speed.
// RL10: Both direction bits while idle start nothing.
// RL11: Both direction bits while jogging are ignored.
// RL12: Fast speed 1..3000, clamped to ramp maximum.
// RL13: Slow speed 1..3000, clamped to ramp maximum.
// RL14: Step distance nonnegative, used at next move.
// RL15: Step wait 1..32767 ms, used at next move.
// RL16: Code -1 ramps down then enters fault state.
// RL17: Code 6 ramps down then holds quick stop.
// RL18: Decel ramp only with velocity profile, else torque.
// RL19: Out-of-range codes are refused, old value kept.
`timescale 1ns/1ps
module lijl_top (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [15:0] PAR_ADDR,
  input wire logic PAR_WR,
  input wire logic PAR_RD,
  input wire logic [15:0] PAR_WDATA,
  output logic [15:0] PAR_RDATA,
  output logic PAR_ACK,
  output logic PAR_ERR,
  input wire logic POWER_ON,
  input wire logic STAGE_ENABLED,
  input wire logic LOCAL_MODE,
  input wire logic [2:0] LINE_IN,
  output logic [2:0] LINE_OUT,
  output logic [2:0] LINE_OE,
  input wire logic [2:0] FREE_OUT_SET,
  input wire logic NO_FAULT,
  input wire logic DRIVE_READY,
  input wire logic POS_LIMIT_IN,
  input wire logic HOMING_TO_SWITCH,
  output logic FAULT_RESET_REQ,
  output logic ENABLE_REQ,
  output logic HALT_REQ,
  output logic [2:0] FREE_IN,
  output logic NEG_LIMIT_HIT,
  output logic POS_LIMIT_HIT,
  output logic HOME_SWITCH_HIT,
  input wire logic [2:0] MOVE_CMD,
  input wire logic JOG_RUNNING,
  input wire logic MOTION_ACTIVE,
  input wire logic [15:0] MAX_RAMP_SPEED,
  output logic JOG_DIR_POS,
  output logic JOG_DIR_NEG,
  output logic [15:0] JOG_SPEED,
  output logic [31:0] JOG_STEP_DIST,
  output logic [15:0] JOG_STEP_WAIT,
  input wire logic QSTOP_REQ,
  input wire logic VEL_PROFILE,
  output logic QS_USE_DECEL_RAMP,
  output logic QS_USE_TORQUE_RAMP,
  output logic QS_STATE_VALID,
  output logic [3:0] QS_TARGET_STATE
);
  logic [15:0] func_sel [3];
  logic [15:0] func_act [3];
  logic [15:0] homing_switch_polarity;
  logic [15:0] negative_limit_polarity;
  logic [15:0] positive_limit_polarity;
  logic [15:0] homing_act;
  logic [15:0] neg_act;
  logic [15:0] pos_act;
  logic [15:0] quick_stop_reaction;
  logic [15:0] manual_slow_speed;
  logic [15:0] manual_fast_speed;
  logic [31:0] manual_step_distance;
  logic [15:0] manual_step_wait;
  logic stage_q;
  logic wr_ok;
  logic hit_map;
  logic [15:0] next_rdata;
  logic [15:0] fast_clamped;
  logic [15:0] slow_clamped;
  logic local_line_2;
  lijl_pkg::lijl_jog_s jog_cmd;
  lijl_pkg::lijl_jog_e jog_state;

  function automatic logic func_valid(input logic [15:0] c,
                                      input logic lim);
    logic ok;
    ok = (c == lijl_pkg::FN_IN_FREE) || (c == lijl_pkg::FN_IN_FAULT_RESET) ||
         (c == lijl_pkg::FN_IN_ENABLE) || (c == lijl_pkg::FN_IN_HALT) ||
         (c == lijl_pkg::FN_IN_JOG_POS) || (c == lijl_pkg::FN_IN_JOG_NEG) ||
         (c == lijl_pkg::FN_IN_JOG_FAST) || (c == lijl_pkg::FN_IN_HOME_SW) ||
         (c == lijl_pkg::FN_OUT_FREE) || (c == lijl_pkg::FN_OUT_NO_FAULT) ||
         (c == lijl_pkg::FN_OUT_READY);
    return ok || (lim && (c == lijl_pkg::FN_IN_NEG_LIMIT));
  endfunction : func_valid

  function automatic logic switch_on(input logic [15:0] pol,
                                     input logic raw);
    logic on;
    on = 1'b0;
    if (pol == lijl_pkg::POL_NC) begin
      on = ~raw;
    end else if (pol == lijl_pkg::POL_NO) begin
      on = raw;
    end
    return on;
  endfunction : switch_on

  function automatic logic speed_ok(input logic [15:0] v);
    return (v >= lijl_pkg::SPEED_MIN) && (v <= lijl_pkg::SPEED_MAX);
  endfunction : speed_ok

  assign local_line_2 = LINE_IN[0];
  assign jog_cmd = lijl_pkg::lijl_jog_s'(MOVE_CMD);
  assign fast_clamped = (manual_fast_speed > MAX_RAMP_SPEED) ?
                        MAX_RAMP_SPEED : manual_fast_speed; // RL12
  assign slow_clamped = (manual_slow_speed > MAX_RAMP_SPEED) ?
                        MAX_RAMP_SPEED : manual_slow_speed; // RL13

  // Write acceptance: address decode and value checks.
  always_comb begin
    wr_ok = 1'b0;
    hit_map = 1'b1;
    next_rdata = 16'h0000;
    if (PAR_ADDR == lijl_pkg::ADDR_LINE2_FUNC) begin
      next_rdata = func_sel[0];
      wr_ok = !STAGE_ENABLED && func_valid(PAR_WDATA, 1'b1); // RL1 RL4
    end else if (PAR_ADDR == lijl_pkg::ADDR_LINE3_FUNC) begin
      next_rdata = func_sel[1];
      wr_ok = !STAGE_ENABLED && func_valid(PAR_WDATA, 1'b0); // RL2 RL4
    end else if (PAR_ADDR == lijl_pkg::ADDR_LINE4_FUNC) begin
      next_rdata = func_sel[2];
      wr_ok = !STAGE_ENABLED && func_valid(PAR_WDATA, 1'b0); // RL2 RL4
    end else if (PAR_ADDR == lijl_pkg::ADDR_NEG_LIM_POL) begin
      next_rdata = negative_limit_polarity;
      wr_ok = !STAGE_ENABLED && (PAR_WDATA <= lijl_pkg::POL_NO); // RL5 RL19
    end else if (PAR_ADDR == lijl_pkg::ADDR_POS_LIM_POL) begin
      next_rdata = positive_limit_polarity;
      wr_ok = !STAGE_ENABLED && (PAR_WDATA <= lijl_pkg::POL_NO); // RL6 RL19
    end else if (PAR_ADDR == lijl_pkg::ADDR_HOMING_POL) begin
      next_rdata = homing_switch_polarity;
      wr_ok = !STAGE_ENABLED && ((PAR_WDATA == lijl_pkg::POL_NC) ||
              (PAR_WDATA == lijl_pkg::POL_NO)); // RL7 RL19
    end else if (PAR_ADDR == lijl_pkg::ADDR_QSTOP_REACT) begin
      next_rdata = quick_stop_reaction;
      wr_ok = (PAR_WDATA == lijl_pkg::QS_FAULT) ||
              (PAR_WDATA == lijl_pkg::QS_HOLD); // RL19
    end else if (PAR_ADDR == lijl_pkg::ADDR_SLOW_SPEED) begin
      next_rdata = manual_slow_speed;
      wr_ok = speed_ok(PAR_WDATA); // RL13
    end else if (PAR_ADDR == lijl_pkg::ADDR_FAST_SPEED) begin
      next_rdata = manual_fast_speed;
      wr_ok = speed_ok(PAR_WDATA); // RL12
    end else if (PAR_ADDR == lijl_pkg::ADDR_STEP_HI) begin
      next_rdata = manual_step_distance[31:16];
      wr_ok = !PAR_WDATA[15]; // RL14
    end else if (PAR_ADDR == lijl_pkg::ADDR_STEP_LO) begin
      next_rdata = manual_step_distance[15:0];
      wr_ok = 1'b1;
    end else if (PAR_ADDR == lijl_pkg::ADDR_STEP_WAIT) begin
      next_rdata = manual_step_wait;
      wr_ok = (PAR_WDATA >= lijl_pkg::WAIT_MIN) &&
              (PAR_WDATA <= lijl_pkg::WAIT_MAX); // RL15
    end else begin
      hit_map = 1'b0;
    end
  end

  // Parameter port answer, one cycle after the strobe.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PAR_RDATA <= 16'h0000;
      PAR_ACK <= 1'b0;
      PAR_ERR <= 1'b0;
    end else begin
      PAR_ACK <= (PAR_WR || PAR_RD) && hit_map;
      PAR_ERR <= (PAR_WR && !(hit_map && wr_ok)) || (PAR_RD && !hit_map);
      if (PAR_RD) begin
        PAR_RDATA <= next_rdata;
      end
    end
  end

  // Stored settings; a refused write leaves the old value.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      func_sel[0] <= lijl_pkg::RST_LINE_FUNC;
      func_sel[1] <= lijl_pkg::RST_LINE_FUNC;
      func_sel[2] <= lijl_pkg::RST_LINE_FUNC;
      homing_switch_polarity <= lijl_pkg::RST_HOMING_POL;
      negative_limit_polarity <= lijl_pkg::RST_NEG_LIM_POL;
      positive_limit_polarity <= lijl_pkg::RST_POS_LIM_POL;
      quick_stop_reaction <= lijl_pkg::RST_QSTOP_REACT;
      manual_slow_speed <= lijl_pkg::RST_SLOW_SPEED;
      manual_fast_speed <= lijl_pkg::RST_FAST_SPEED;
      manual_step_distance <= lijl_pkg::RST_STEP_DIST;
      manual_step_wait <= lijl_pkg::RST_STEP_WAIT;
    end else if (PAR_WR && wr_ok) begin // RL19
      if (PAR_ADDR == lijl_pkg::ADDR_LINE2_FUNC) begin
        func_sel[0] <= PAR_WDATA;
      end else if (PAR_ADDR == lijl_pkg::ADDR_LINE3_FUNC) begin
        func_sel[1] <= PAR_WDATA;
      end else if (PAR_ADDR == lijl_pkg::ADDR_LINE4_FUNC) begin
        func_sel[2] <= PAR_WDATA;
      end else if (PAR_ADDR == lijl_pkg::ADDR_NEG_LIM_POL) begin
        negative_limit_polarity <= PAR_WDATA;
      end else if (PAR_ADDR == lijl_pkg::ADDR_POS_LIM_POL) begin
        positive_limit_polarity <= PAR_WDATA;
      end else if (PAR_ADDR == lijl_pkg::ADDR_HOMING_POL) begin
        homing_switch_polarity <= PAR_WDATA;
      end else if (PAR_ADDR == lijl_pkg::ADDR_QSTOP_REACT) begin
        quick_stop_reaction <= PAR_WDATA;
      end else if (PAR_ADDR == lijl_pkg::ADDR_SLOW_SPEED) begin
        manual_slow_speed <= PAR_WDATA;
      end else if (PAR_ADDR == lijl_pkg::ADDR_FAST_SPEED) begin
        manual_fast_speed <= PAR_WDATA;
      end else if (PAR_ADDR == lijl_pkg::ADDR_STEP_HI) begin
        manual_step_distance[31:16] <= PAR_WDATA;
      end else if (PAR_ADDR == lijl_pkg::ADDR_STEP_LO) begin
        manual_step_distance[15:0] <= PAR_WDATA;
      end else if (PAR_ADDR == lijl_pkg::ADDR_STEP_WAIT) begin
        manual_step_wait <= PAR_WDATA;
      end
    end
  end

  // Function assignments in use change only on a power-on pulse.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      func_act[0] <= lijl_pkg::RST_LINE_FUNC;
      func_act[1] <= lijl_pkg::RST_LINE_FUNC;
      func_act[2] <= lijl_pkg::RST_LINE_FUNC;
    end else if (POWER_ON) begin
      func_act[0] <= func_sel[0]; // RL4
      func_act[1] <= func_sel[1]; // RL4
      func_act[2] <= func_sel[2]; // RL4
    end
  end

  // Switch polarities in use change on the stage enable edge.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      stage_q <= 1'b0;
      homing_act <= lijl_pkg::RST_HOMING_POL;
      neg_act <= lijl_pkg::RST_NEG_LIM_POL;
      pos_act <= lijl_pkg::RST_POS_LIM_POL;
    end else begin
      stage_q <= STAGE_ENABLED;
      if (STAGE_ENABLED && !stage_q) begin
        homing_act <= homing_switch_polarity; // RL8
        neg_act <= negative_limit_polarity; // RL8
        pos_act <= positive_limit_polarity; // RL8
      end
    end
  end

  // Input functions and output drive of lines 2 to 4.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      FAULT_RESET_REQ <= 1'b0;
      ENABLE_REQ <= 1'b0;
      HALT_REQ <= 1'b0;
      FREE_IN <= 3'h0;
      LINE_OUT <= 3'h0;
      LINE_OE <= 3'h0;
      HOME_SWITCH_HIT <= 1'b0;
      NEG_LIMIT_HIT <= 1'b0;
      POS_LIMIT_HIT <= 1'b0;
    end else begin
      FAULT_RESET_REQ <= LOCAL_MODE && (
        ((func_act[0] == lijl_pkg::FN_IN_FAULT_RESET) && LINE_IN[0]) ||
        ((func_act[1] == lijl_pkg::FN_IN_FAULT_RESET) && LINE_IN[1]) ||
        ((func_act[2] == lijl_pkg::FN_IN_FAULT_RESET) && LINE_IN[2])); // RL3
      ENABLE_REQ <= LOCAL_MODE && (
        ((func_act[0] == lijl_pkg::FN_IN_ENABLE) && LINE_IN[0]) ||
        ((func_act[1] == lijl_pkg::FN_IN_ENABLE) && LINE_IN[1]) ||
        ((func_act[2] == lijl_pkg::FN_IN_ENABLE) && LINE_IN[2])); // RL3
      HALT_REQ <=
        ((func_act[0] == lijl_pkg::FN_IN_HALT) && LINE_IN[0]) ||
        ((func_act[1] == lijl_pkg::FN_IN_HALT) && LINE_IN[1]) ||
        ((func_act[2] == lijl_pkg::FN_IN_HALT) && LINE_IN[2]);
      HOME_SWITCH_HIT <= HOMING_TO_SWITCH && (
        ((func_act[0] == lijl_pkg::FN_IN_HOME_SW) &&
         switch_on(homing_act, LINE_IN[0])) ||
        ((func_act[1] == lijl_pkg::FN_IN_HOME_SW) &&
         switch_on(homing_act, LINE_IN[1])) ||
        ((func_act[2] == lijl_pkg::FN_IN_HOME_SW) &&
         switch_on(homing_act, LINE_IN[2]))); // RL7
      NEG_LIMIT_HIT <= (func_act[0] == lijl_pkg::FN_IN_NEG_LIMIT) &&
                       switch_on(neg_act, local_line_2); // RL1 RL5
      POS_LIMIT_HIT <= switch_on(pos_act, POS_LIMIT_IN); // RL6
      for (int i = 0; i < 3; i++) begin
        FREE_IN[i] <= (func_act[i] == lijl_pkg::FN_IN_FREE) && LINE_IN[i];
        LINE_OE[i] <= func_act[i] >= lijl_pkg::FN_OUT_FREE;
        if (func_act[i] == lijl_pkg::FN_OUT_FREE) begin
          LINE_OUT[i] <= FREE_OUT_SET[i];
        end else if (func_act[i] == lijl_pkg::FN_OUT_NO_FAULT) begin
          LINE_OUT[i] <= NO_FAULT;
        end else if (func_act[i] == lijl_pkg::FN_OUT_READY) begin
          LINE_OUT[i] <= DRIVE_READY;
        end else begin
          LINE_OUT[i] <= 1'b0;
        end
      end
    end
  end

  // Jog direction decode from the command word.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      jog_state <= lijl_pkg::JOG_IDLE;
    end else begin
      case (jog_state)
        lijl_pkg::JOG_IDLE: begin
          if (jog_cmd.pos && !jog_cmd.neg) begin // RL9 RL10
            jog_state <= lijl_pkg::JOG_POS;
          end else if (jog_cmd.neg && !jog_cmd.pos) begin // RL9 RL10
            jog_state <= lijl_pkg::JOG_NEG;
          end
        end
        lijl_pkg::JOG_POS: begin
          if (!jog_cmd.pos && !jog_cmd.neg) begin
            jog_state <= lijl_pkg::JOG_IDLE;
          end else if (jog_cmd.neg && !jog_cmd.pos) begin
            jog_state <= lijl_pkg::JOG_NEG;
          end else if (!JOG_RUNNING && jog_cmd.neg) begin
            jog_state <= lijl_pkg::JOG_IDLE; // RL10
          end
        end
        lijl_pkg::JOG_NEG: begin
          if (!jog_cmd.pos && !jog_cmd.neg) begin
            jog_state <= lijl_pkg::JOG_IDLE;
          end else if (jog_cmd.pos && !jog_cmd.neg) begin
            jog_state <= lijl_pkg::JOG_POS;
          end else if (!JOG_RUNNING && jog_cmd.pos) begin
            jog_state <= lijl_pkg::JOG_IDLE; // RL10
          end
        end
        default: begin
          jog_state <= lijl_pkg::JOG_IDLE;
        end
      endcase
    end
  end

  // Jog outputs; a running move keeps its direction on both bits.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      JOG_DIR_POS <= 1'b0;
      JOG_DIR_NEG <= 1'b0;
      JOG_SPEED <= lijl_pkg::RST_SLOW_SPEED;
      JOG_STEP_DIST <= lijl_pkg::RST_STEP_DIST;
      JOG_STEP_WAIT <= lijl_pkg::RST_STEP_WAIT;
    end else begin
      JOG_DIR_POS <= jog_state == lijl_pkg::JOG_POS; // RL11
      JOG_DIR_NEG <= jog_state == lijl_pkg::JOG_NEG; // RL11
      JOG_SPEED <= jog_cmd.fast ? fast_clamped : slow_clamped; // RL9
      if (!MOTION_ACTIVE) begin
        JOG_STEP_DIST <= manual_step_distance; // RL14
        JOG_STEP_WAIT <= manual_step_wait; // RL15
      end
    end
  end

  // Quick-stop reaction selection.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      QS_USE_DECEL_RAMP <= 1'b0;
      QS_USE_TORQUE_RAMP <= 1'b0;
      QS_STATE_VALID <= 1'b0;
      QS_TARGET_STATE <= lijl_pkg::STATE_QSTOP;
    end else begin
      QS_USE_DECEL_RAMP <= QSTOP_REQ && VEL_PROFILE; // RL18
      QS_USE_TORQUE_RAMP <= QSTOP_REQ && !VEL_PROFILE; // RL18
      QS_STATE_VALID <= QSTOP_REQ;
      if (quick_stop_reaction == lijl_pkg::QS_FAULT) begin
        QS_TARGET_STATE <= lijl_pkg::STATE_FAULT; // RL16
      end else begin
        QS_TARGET_STATE <= lijl_pkg::STATE_QSTOP; // RL17
      end
    end
  end
endmodule : lijl_top

// *** verification/lijl_checker.sv ***
// Concurrent checks on the ports of the control block.
`timescale 1ns/1ps
module lijl_checker (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PAR_WR,
  input wire logic PAR_RD,
  input wire logic PAR_ACK,
  input wire logic PAR_ERR,
  input wire logic LOCAL_MODE,
  input wire logic ENABLE_REQ,
  input wire logic FAULT_RESET_REQ,
  input wire logic HOMING_TO_SWITCH,
  input wire logic HOME_SWITCH_HIT,
  input wire logic [2:0] MOVE_CMD,
  input wire logic JOG_RUNNING,
  input wire logic JOG_DIR_POS,
  input wire logic JOG_DIR_NEG,
  input wire logic [15:0] MAX_RAMP_SPEED,
  input wire logic [15:0] JOG_SPEED,
  input wire logic QSTOP_REQ,
  input wire logic VEL_PROFILE,
  input wire logic QS_USE_DECEL_RAMP,
  input wire logic QS_USE_TORQUE_RAMP
);
  default clocking dc @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_both_idle;
    (MOVE_CMD[1:0] == 2'b11 && !JOG_RUNNING) [*3];
  endsequence
  sequence s_both_run;
    (MOVE_CMD[1:0] == 2'b11 && JOG_RUNNING && JOG_DIR_POS) [*2];
  endsequence
  AST_ANSWER: assert property (
    (PAR_WR || PAR_RD) |=> PAR_ACK || PAR_ERR)
    else $error("parameter strobe not answered");
  AST_LOCAL_ONLY: assert property (
    !LOCAL_MODE |=> !ENABLE_REQ && !FAULT_RESET_REQ)
    else $error("enable or fault reset outside local mode");
  AST_HOME_GATE: assert property (
    !HOMING_TO_SWITCH |=> !HOME_SWITCH_HIT)
    else $error("homing switch seen outside homing move");
  AST_BOTH_IDLE: assert property (
    s_both_idle |-> !JOG_DIR_POS && !JOG_DIR_NEG)
    else $error("movement with both direction bits");
  AST_BOTH_RUN: assert property (
    s_both_run |=> JOG_DIR_POS && !JOG_DIR_NEG)
    else $error("running jog changed by both direction bits");
  AST_CLAMP: assert property (
    $stable(MAX_RAMP_SPEED) [*2] |-> JOG_SPEED <= MAX_RAMP_SPEED)
    else $error("jog speed above ramp maximum");
  AST_DECEL: assert property (
    QSTOP_REQ && VEL_PROFILE |=>
    QS_USE_DECEL_RAMP && !QS_USE_TORQUE_RAMP)
    else $error("deceleration ramp not chosen");
  AST_TORQUE: assert property (
    QSTOP_REQ && !VEL_PROFILE |=>
    QS_USE_TORQUE_RAMP && !QS_USE_DECEL_RAMP)
    else $error("torque ramp not chosen");
endmodule : lijl_checker

// *** verification/lijl_master.sv ***
// Fieldbus master model that issues parameter reads and writes.
`timescale 1ns/1ps
module lijl_master (
  input wire logic CLK,
  output logic [15:0] PAR_ADDR,
  output logic PAR_WR,
  output logic PAR_RD,
  output logic [15:0] PAR_WDATA,
  input wire logic [15:0] PAR_RDATA,
  input wire logic PAR_ACK,
  input wire logic PAR_ERR
);
  initial begin
    PAR_ADDR = 16'h0000;
    PAR_WR = 1'b0;
    PAR_RD = 1'b0;
    PAR_WDATA = 16'h0000;
  end
  // One strobe cycle; the answer is taken once it stands, then released.
  task automatic access(input logic w, input logic [15:0] a,
    input logic [15:0] d, output logic [17:0] rsp);
    @(posedge CLK);
    #1;
    PAR_ADDR = a;
    PAR_WDATA = d;
    PAR_WR = w;
    PAR_RD = !w;
    @(posedge CLK);
    #1;
    rsp = {PAR_ACK, PAR_ERR, PAR_RDATA};
    PAR_WR = 1'b0;
    PAR_RD = 1'b0;
    PAR_ADDR = ~a;
    PAR_WDATA = ~d;
  endtask : access
endmodule : lijl_master

// *** verification/local_io_jog_limit_control_test.sv ***
// Self-checking testbench of the local I/O, jog and quick-stop block.
`timescale 1ns/1ps
module local_io_jog_limit_control_test;
  logic CLK, SYS_RST, PAR_WR, PAR_RD, PAR_ACK, PAR_ERR, POWER_ON;
  logic STAGE_ENABLED, LOCAL_MODE, NO_FAULT, DRIVE_READY, POS_LIMIT_IN;
  logic HOMING_TO_SWITCH, FAULT_RESET_REQ, ENABLE_REQ, HALT_REQ;
  logic NEG_LIMIT_HIT, POS_LIMIT_HIT, HOME_SWITCH_HIT, JOG_RUNNING;
  logic MOTION_ACTIVE, JOG_DIR_POS, JOG_DIR_NEG, QSTOP_REQ, VEL_PROFILE;
  logic QS_USE_DECEL_RAMP, QS_USE_TORQUE_RAMP, QS_STATE_VALID;
  logic [2:0] LINE_IN, LINE_OUT, LINE_OE, FREE_OUT_SET, FREE_IN, MOVE_CMD;
  logic [15:0] PAR_ADDR, PAR_WDATA, PAR_RDATA, MAX_RAMP_SPEED, JOG_SPEED;
  logic [15:0] JOG_STEP_WAIT;
  logic [31:0] JOG_STEP_DIST;
  logic [3:0] QS_TARGET_STATE;
  logic [17:0] rsp;
  logic [15:0] pol, hpol, npol, spd;
  logic [15:0] codes [12] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004,
    16'h0009, 16'h000A, 16'h000B, 16'h0014, 16'h0016, 16'h0065, 16'h0066,
    16'h0067};
  int failures = 0;
  int samples_checked = 0;

  lijl_top DUT (.*);
  lijl_master MST (.*);

  always #2.5 CLK = ~CLK;

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : cyc

  task automatic wr(input logic [15:0] a, input logic [15:0] d,
    input logic err);
    MST.access(1'b1, a, d, rsp);
    chk({30'h0, rsp[17:16]}, {30'h0, 1'b1, err});
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    MST.access(1'b0, a, 16'h0000, rsp);
    chk({14'h0, rsp}, {14'h0, 2'b10, exp});
  endtask : rd

  task automatic power_on;
    POWER_ON = 1'b1;
    cyc(1);
    POWER_ON = 1'b0;
    cyc(2);
  endtask : power_on

  // Switch evaluation: closed contact idles high, open contact idles low.
  function automatic logic hit(input logic [15:0] p, input logic l);
    return (p == 16'h0001) ? !l : (p == 16'h0002) ? l : 1'b0;
  endfunction : hit

  initial begin
    repeat (20000) @(posedge CLK);
    failures++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    close_out;
  end

  initial begin
    CLK = 1'b0;
    SYS_RST = 1'b1;
    POWER_ON = 1'b0;
    STAGE_ENABLED = 1'b0;
    LOCAL_MODE = 1'b1;
    LINE_IN = 3'h7;
    FREE_OUT_SET = 3'h0;
    NO_FAULT = 1'b1;
    DRIVE_READY = 1'b1;
    POS_LIMIT_IN = 1'b1;
    HOMING_TO_SWITCH = 1'b0;
    MOVE_CMD = 3'h0;
    JOG_RUNNING = 1'b0;
    MOTION_ACTIVE = 1'b0;
    MAX_RAMP_SPEED = 16'h0BB8;
    QSTOP_REQ = 1'b0;
    VEL_PROFILE = 1'b0;
    npol = 16'h0001;
    void'($urandom(86284));
    repeat (12) @(posedge CLK);
    #1 SYS_RST = 1'b0;
    rd(lijl_pkg::ADDR_NEG_LIM_POL, 16'h0001);
    rd(lijl_pkg::ADDR_POS_LIM_POL, 16'h0001);
    rd(lijl_pkg::ADDR_HOMING_POL, 16'h0001);
    rd(lijl_pkg::ADDR_QSTOP_REACT, 16'h0006);
    rd(lijl_pkg::ADDR_FAST_SPEED, 16'h00B4);
    rd(lijl_pkg::ADDR_SLOW_SPEED, 16'h003C);
    rd(lijl_pkg::ADDR_STEP_LO, 16'h0014);
    rd(lijl_pkg::ADDR_STEP_WAIT, 16'h01F4);
    MST.access(1'b0, 16'h0001, 16'h0000, rsp);
    chk({30'h0, rsp[17:16]}, 32'h1);
    wr(lijl_pkg::ADDR_NEG_LIM_POL, 16'h0003, 1'b1);
    wr(lijl_pkg::ADDR_HOMING_POL, 16'h0000, 1'b1);
    wr(lijl_pkg::ADDR_QSTOP_REACT, 16'h0005, 1'b1);
    wr(lijl_pkg::ADDR_FAST_SPEED, 16'h0BB9, 1'b1);
    wr(lijl_pkg::ADDR_SLOW_SPEED, 16'h0000, 1'b1);
    wr(lijl_pkg::ADDR_STEP_WAIT, 16'h8000, 1'b1);
    wr(lijl_pkg::ADDR_STEP_HI, 16'h8000, 1'b1);
    rd(lijl_pkg::ADDR_NEG_LIM_POL, 16'h0001);
    foreach (codes[i]) begin
      wr(lijl_pkg::ADDR_LINE2_FUNC, codes[i], 1'b0);
      wr(lijl_pkg::ADDR_LINE3_FUNC, codes[i], codes[i] == 16'h0016);
    end
    wr(lijl_pkg::ADDR_LINE2_FUNC, 16'h0015, 1'b1);
    wr(lijl_pkg::ADDR_LINE4_FUNC, 16'h0016, 1'b1);
    wr(lijl_pkg::ADDR_LINE2_FUNC, 16'h0003, 1'b0);
    wr(lijl_pkg::ADDR_LINE3_FUNC, 16'h0014, 1'b0);
    wr(lijl_pkg::ADDR_LINE4_FUNC, 16'h0067, 1'b0);
    STAGE_ENABLED = 1'b1;
    wr(lijl_pkg::ADDR_LINE2_FUNC, 16'h0001, 1'b1);
    wr(lijl_pkg::ADDR_POS_LIM_POL, 16'h0000, 1'b1);
    STAGE_ENABLED = 1'b0;
    cyc(2);
    chk(ENABLE_REQ, 32'h0);
    chk(FREE_IN, 32'h7);
    power_on;
    chk({ENABLE_REQ, HALT_REQ, FAULT_RESET_REQ}, 32'h4);
    chk({LINE_OE, LINE_OUT[2]}, 32'h9);
    LOCAL_MODE = 1'b0;
    cyc(2);
    chk(ENABLE_REQ, 32'h0);
    wr(lijl_pkg::ADDR_LINE2_FUNC, 16'h0016, 1'b0);
    power_on;
    for (int i = 0; i < 8; i++) begin
      pol = 16'($urandom_range(2));
      hpol = 16'($urandom_range(2, 1));
      LINE_IN = 3'($urandom);
      POS_LIMIT_IN = 1'($urandom);
      HOMING_TO_SWITCH = 1'($urandom);
      wr(lijl_pkg::ADDR_NEG_LIM_POL, pol, 1'b0);
      wr(lijl_pkg::ADDR_POS_LIM_POL, pol, 1'b0);
      wr(lijl_pkg::ADDR_HOMING_POL, hpol, 1'b0);
      cyc(2);
      chk(NEG_LIMIT_HIT, hit(npol, LINE_IN[0]));
      STAGE_ENABLED = 1'b1;
      cyc(2);
      chk(NEG_LIMIT_HIT, hit(pol, LINE_IN[0]));
      chk(POS_LIMIT_HIT, hit(pol, POS_LIMIT_IN));
      chk(HOME_SWITCH_HIT, HOMING_TO_SWITCH & hit(hpol, LINE_IN[1]));
      STAGE_ENABLED = 1'b0;
      npol = pol;
    end
    MOVE_CMD = 3'b001;
    cyc(3);
    chk({JOG_DIR_POS, JOG_DIR_NEG, JOG_SPEED}, {14'h0, 2'b10, 16'h003C});
    MOVE_CMD = 3'b101;
    cyc(2);
    chk(JOG_SPEED, 32'h00B4);
    MAX_RAMP_SPEED = 16'h0064;
    cyc(2);
    chk(JOG_SPEED, 32'h0064);
    JOG_RUNNING = 1'b1;
    MOVE_CMD = 3'b111;
    cyc(3);
    chk({JOG_DIR_POS, JOG_DIR_NEG}, 32'h2);
    JOG_RUNNING = 1'b0;
    cyc(3);
    chk({JOG_DIR_POS, JOG_DIR_NEG}, 32'h0);
    MOVE_CMD = 3'b010;
    spd = 16'($urandom_range(3000, 1));
    wr(lijl_pkg::ADDR_SLOW_SPEED, spd, 1'b0);
    cyc(2);
    if (spd > 16'h0064) begin
      spd = 16'h0064;
    end
    chk({JOG_DIR_NEG, JOG_SPEED}, {1'b1, spd});
    MOVE_CMD = 3'b000;
    MOTION_ACTIVE = 1'b1;
    wr(lijl_pkg::ADDR_STEP_HI, 16'h0001, 1'b0);
    wr(lijl_pkg::ADDR_STEP_LO, 16'h2345, 1'b0);
    wr(lijl_pkg::ADDR_STEP_WAIT, 16'h7FFF, 1'b0);
    cyc(2);
    chk(JOG_STEP_DIST, 32'h0000_0014);
    MOTION_ACTIVE = 1'b0;
    cyc(2);
    chk(JOG_STEP_DIST, 32'h0001_2345);
    chk(JOG_STEP_WAIT, 32'h7FFF);
    QSTOP_REQ = 1'b1;
    VEL_PROFILE = 1'b1;
    wr(lijl_pkg::ADDR_QSTOP_REACT, 16'hFFFF, 1'b0);
    cyc(2);
    chk({QS_STATE_VALID, QS_TARGET_STATE}, 32'h19);
    chk({QS_USE_DECEL_RAMP, QS_USE_TORQUE_RAMP}, 32'h2);
    VEL_PROFILE = 1'b0;
    wr(lijl_pkg::ADDR_QSTOP_REACT, 16'h0006, 1'b0);
    cyc(2);
    chk({QS_STATE_VALID, QS_TARGET_STATE}, 32'h17);
    chk({QS_USE_DECEL_RAMP, QS_USE_TORQUE_RAMP}, 32'h1);
    SYS_RST = 1'b1;
    cyc(2);
    SYS_RST = 1'b0;
    rd(lijl_pkg::ADDR_FAST_SPEED, 16'h00B4);
    close_out;
  end
endmodule : local_io_jog_limit_control_test

bind lijl_top lijl_checker CHK (.*);
